// ===== mpg_pkg.sv
// Constants shared by the miscellaneous pin, strap and GPIO control block
// Behaviour
// - Drive EEPROM clock pin while accessing EEPROM
// - EEPROM data pin carries data both ways
// - Idle EEPROM data pin sits at one
// - Normally scan pin is output holding zero
// - Manufacturing test turns scan pin into input
// - GPIO direction follows output enable register bits
// - GPIO seven to five give SMBus address
// - Debug mode reads GPIO four to zero
// - Power saving strap sampled at reset
// - Debug strap low enters debug mode
// - Port status driven only in debug mode with enable strap
// - Three port status outputs for ports 0-2
package mpg_pkg;

    // Register byte addresses on the APB
    localparam logic [7:0] ADDR_GPIO_OE  = 8'h00;
    localparam logic [7:0] ADDR_GPIO_OUT = 8'h04;
    localparam logic [7:0] ADDR_GPIO_IN  = 8'h08;
    localparam logic [7:0] ADDR_STRAP    = 8'h0c;
    localparam logic [7:0] ADDR_EE_CTRL  = 8'h10;

    // Values after reset
    localparam logic [7:0] RST_GPIO_OE  = 8'h00;
    localparam logic [7:0] RST_GPIO_OUT = 8'h00;
    localparam logic [3:0] RST_EE_CTRL  = 4'h0;

    // EEPROM control register fields
    localparam int EE_ACTIVE = 0;
    localparam int EE_CLK    = 1;
    localparam int EE_DRIVE  = 2;
    localparam int EE_DOUT   = 3;
    localparam int EE_DIN    = 4;

    // Strap status register fields
    localparam int ST_SMB_LSB = 0;
    localparam int ST_PWR     = 3;
    localparam int ST_DBG     = 4;
    localparam int ST_STOE    = 5;
    localparam int ST_SMBCLK  = 6;
    localparam int ST_MFG     = 7;
    localparam int ST_SEL_LSB = 8;
    localparam int ST_DONE    = 13;
    localparam int ST_SCANIN  = 14;

    // Positions within the synchronised pin vector
    localparam int SY_GPIO   = 0;
    localparam int SY_EEDATA = 8;
    localparam int SY_SMBCLK = 9;
    localparam int SY_SCANIN = 10;
    localparam int SY_MFG    = 11;
    localparam int SY_PWR    = 12;
    localparam int SY_DBG    = 13;
    localparam int SY_STOE   = 14;
    localparam int SYNC_W    = 15;

    // Cycles after reset release before straps are captured
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

endpackage

// ===== mpg_sync.sv
// Two-flop synchroniser for pins arriving from outside the clock domain
module mpg_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta <= {W{1'b0}};
            q    <= {W{1'b0}};
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end

endmodule

// ===== mpg_strap.sv
// Strap capture: samples board straps once after reset release and holds them
module mpg_strap (
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       power_saving_strap_s,
    input  wire logic       debug_enable_strap_s,
    input  wire logic [2:0] smbus_addr_pins_s,
    output logic            strap_done,
    output logic            power_saving_enable,
    output logic            debug_mode,
    output logic      [2:0] smbus_address
);

    logic [1:0] settle;
    logic [1:0] next_settle;
    logic       next_strap_done;
    logic       next_power_saving_enable;
    logic       next_debug_mode;
    logic [2:0] next_smbus_address;

    // Wait out the synchroniser depth so its reset zeros are never captured
    always_comb begin
        next_settle              = settle;
        next_strap_done          = strap_done;
        next_power_saving_enable = power_saving_enable;
        next_debug_mode          = debug_mode;
        next_smbus_address       = smbus_address;
        if (!strap_done) begin
            if (settle == mpg_pkg::STRAP_SETTLE) begin
                next_strap_done          = 1'b1;
                next_power_saving_enable = power_saving_strap_s;
                next_debug_mode          = !debug_enable_strap_s;
                next_smbus_address       = smbus_addr_pins_s;
            end else begin
                next_settle = settle + 2'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            settle              <= 2'h0;
            strap_done          <= 1'b0;
            power_saving_enable <= 1'b0;
            debug_mode          <= 1'b0;
            smbus_address       <= 3'h0;
        end else begin
            settle              <= next_settle;
            strap_done          <= next_strap_done;
            power_saving_enable <= next_power_saving_enable;
            debug_mode          <= next_debug_mode;
            smbus_address       <= next_smbus_address;
        end
    end

endmodule

// ===== mpg_top.sv
// Miscellaneous pin control: GPIO, EEPROM pins, scan pin, straps, APB registers
//
// The APB register port and the address map were left to the implementer.
module mpg_top (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  gpio_in,
    output logic      [7:0]  gpio_out,
    output logic      [7:0]  gpio_oe_n,
    output logic             eeprom_serial_clock,
    input  wire logic        eeprom_serial_data_in,
    output logic             eeprom_serial_data_out,
    output logic             eeprom_serial_data_oe_n,
    input  wire logic        smbus_clock_in,
    input  wire logic        scan_enable_in,
    output logic             scan_enable_out,
    output logic             scan_enable_oe_n,
    input  wire logic        manufacturing_test,
    input  wire logic        power_saving_strap,
    input  wire logic        debug_enable_strap,
    input  wire logic        status_output_enable_strap,
    input  wire logic [2:0]  port_status_src,
    output logic      [2:0]  port_status,
    output logic             port_status_oe_n,
    output logic             power_saving_enable,
    output logic             debug_mode,
    output logic      [4:0]  debug_select,
    output logic      [2:0]  smbus_address
);

    logic [mpg_pkg::SYNC_W-1:0] pins_s;
    logic [7:0]  gpio_s;
    logic        eedata_s;
    logic        smbclk_s;
    logic        scanin_s;
    logic        mfg_s;
    logic        pwr_s;
    logic        dbg_s;
    logic        stoe_s;
    logic        strap_done;

    logic [7:0]  gpio_oe;
    logic [3:0]  ee_ctrl;
    logic [31:0] rd_word;
    logic [31:0] strap_word;
    logic        access;
    logic        done_xfer;

    logic [7:0]  next_gpio_oe;
    logic [7:0]  next_gpio_out;
    logic [3:0]  next_ee_ctrl;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    logic [7:0]  next_gpio_oe_n;
    logic        next_ee_clock;
    logic        next_ee_dout;
    logic        next_ee_oe_n;
    logic        next_scan_out;
    logic        next_scan_oe_n;
    logic [2:0]  next_port_status;
    logic        next_port_status_oe_n;
    logic [4:0]  next_debug_select;

    // Every off-chip input, the SMBus clock included, is only ever sampled
    mpg_sync #(
        .W (mpg_pkg::SYNC_W)
    ) u_sync (
        .clock  (clock),
        .arst_n (arst_n),
        .d      ({status_output_enable_strap, debug_enable_strap, power_saving_strap,
                  manufacturing_test, scan_enable_in, smbus_clock_in,
                  eeprom_serial_data_in, gpio_in}),
        .q      (pins_s)
    );

    assign gpio_s   = pins_s[mpg_pkg::SY_GPIO +: 8];
    assign eedata_s = pins_s[mpg_pkg::SY_EEDATA];
    assign smbclk_s = pins_s[mpg_pkg::SY_SMBCLK];
    assign scanin_s = pins_s[mpg_pkg::SY_SCANIN];
    assign mfg_s    = pins_s[mpg_pkg::SY_MFG];
    assign pwr_s    = pins_s[mpg_pkg::SY_PWR];
    assign dbg_s    = pins_s[mpg_pkg::SY_DBG];
    assign stoe_s   = pins_s[mpg_pkg::SY_STOE];

    mpg_strap u_strap (
        .clock                (clock),
        .arst_n               (arst_n),
        .power_saving_strap_s (pwr_s),
        .debug_enable_strap_s (dbg_s),
        .smbus_addr_pins_s    (gpio_s[7:5]),
        .strap_done           (strap_done),
        .power_saving_enable  (power_saving_enable),
        .debug_mode           (debug_mode),
        .smbus_address        (smbus_address)
    );

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == mpg_pkg::ADDR_GPIO_OE) || (a == mpg_pkg::ADDR_GPIO_OUT) ||
                  (a == mpg_pkg::ADDR_GPIO_IN) || (a == mpg_pkg::ADDR_STRAP) ||
                  (a == mpg_pkg::ADDR_EE_CTRL);
    endfunction

    // ------------------------------------------------------------------
    // APB slave: one wait state, pready rises in the second access cycle
    // ------------------------------------------------------------------
    assign access    = psel && penable && !pready;
    assign done_xfer = psel && penable && pready;

    always_comb begin
        strap_word = 32'h0;
        strap_word[mpg_pkg::ST_SMB_LSB +: 3] = smbus_address;
        strap_word[mpg_pkg::ST_PWR]          = power_saving_enable;
        strap_word[mpg_pkg::ST_DBG]          = debug_mode;
        strap_word[mpg_pkg::ST_STOE]         = stoe_s;
        strap_word[mpg_pkg::ST_SMBCLK]       = smbclk_s;
        strap_word[mpg_pkg::ST_MFG]          = mfg_s;
        strap_word[mpg_pkg::ST_SEL_LSB +: 5] = debug_select;
        strap_word[mpg_pkg::ST_DONE]         = strap_done;
        strap_word[mpg_pkg::ST_SCANIN]       = scanin_s;
    end

    always_comb begin
        case (paddr)
            mpg_pkg::ADDR_GPIO_OE:  rd_word = {24'h0, gpio_oe};
            mpg_pkg::ADDR_GPIO_OUT: rd_word = {24'h0, gpio_out};
            mpg_pkg::ADDR_GPIO_IN:  rd_word = {24'h0, gpio_s};
            mpg_pkg::ADDR_STRAP:    rd_word = strap_word;
            mpg_pkg::ADDR_EE_CTRL:  rd_word = {27'h0, eedata_s, ee_ctrl};
            default:                rd_word = 32'h0;
        endcase
    end

    always_comb begin
        next_gpio_oe  = gpio_oe;
        next_gpio_out = gpio_out;
        next_ee_ctrl  = ee_ctrl;
        next_prdata   = prdata;
        next_pready   = 1'b0;
        next_pslverr  = 1'b0;
        if (access) begin
            next_pready  = 1'b1;
            next_pslverr = !reg_hit(paddr);
            next_prdata  = pwrite ? 32'h0 : rd_word;
        end
        // Writes land only on the completing edge, never in the wait cycle
        if (done_xfer && pwrite) begin
            case (paddr)
                mpg_pkg::ADDR_GPIO_OE:  next_gpio_oe  = pwdata[7:0];
                mpg_pkg::ADDR_GPIO_OUT: next_gpio_out = pwdata[7:0];
                mpg_pkg::ADDR_EE_CTRL:  next_ee_ctrl  = pwdata[3:0];
                default:                next_gpio_oe  = gpio_oe;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            gpio_oe  <= mpg_pkg::RST_GPIO_OE;
            gpio_out <= mpg_pkg::RST_GPIO_OUT;
            ee_ctrl  <= mpg_pkg::RST_EE_CTRL;
            prdata   <= 32'h0;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end else begin
            gpio_oe  <= next_gpio_oe;
            gpio_out <= next_gpio_out;
            ee_ctrl  <= next_ee_ctrl;
            prdata   <= next_prdata;
            pready   <= next_pready;
            pslverr  <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers, all registered so pads see no combinational glitches
    // ------------------------------------------------------------------
    always_comb begin
        next_gpio_oe_n = ~gpio_oe;
        next_ee_clock  = ee_ctrl[mpg_pkg::EE_ACTIVE] && ee_ctrl[mpg_pkg::EE_CLK];
        if (ee_ctrl[mpg_pkg::EE_ACTIVE]) begin
            next_ee_dout = ee_ctrl[mpg_pkg::EE_DOUT];
            next_ee_oe_n = !ee_ctrl[mpg_pkg::EE_DRIVE];
        end else begin
            // Idle line held at one so the EEPROM never sees a false start
            next_ee_dout = 1'b1;
            next_ee_oe_n = 1'b0;
        end
        next_scan_out  = 1'b0;
        next_scan_oe_n = mfg_s;
        next_port_status_oe_n = !(debug_mode && stoe_s);
        next_port_status = next_port_status_oe_n ? 3'h0 : port_status_src;
        next_debug_select = debug_mode ? gpio_s[4:0] : 5'h0;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            gpio_oe_n               <= ~mpg_pkg::RST_GPIO_OE;
            eeprom_serial_clock     <= 1'b0;
            eeprom_serial_data_out  <= 1'b1;
            eeprom_serial_data_oe_n <= 1'b0;
            scan_enable_out         <= 1'b0;
            scan_enable_oe_n        <= 1'b0;
            port_status             <= 3'h0;
            port_status_oe_n        <= 1'b1;
            debug_select            <= 5'h0;
        end else begin
            gpio_oe_n               <= next_gpio_oe_n;
            eeprom_serial_clock     <= next_ee_clock;
            eeprom_serial_data_out  <= next_ee_dout;
            eeprom_serial_data_oe_n <= next_ee_oe_n;
            scan_enable_out         <= next_scan_out;
            scan_enable_oe_n        <= next_scan_oe_n;
            port_status             <= next_port_status;
            port_status_oe_n        <= next_port_status_oe_n;
            debug_select            <= next_debug_select;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    property p_ee_clock;
        ee_ctrl[mpg_pkg::EE_ACTIVE] |=> eeprom_serial_clock == $past(ee_ctrl[mpg_pkg::EE_CLK]);
    endproperty
    a_ee_clock: assert property (p_ee_clock) else $error("eeprom clock not driven");

    property p_ee_data;
        ee_ctrl[mpg_pkg::EE_ACTIVE] && ee_ctrl[mpg_pkg::EE_DRIVE] |=>
            !eeprom_serial_data_oe_n && eeprom_serial_data_out == $past(ee_ctrl[mpg_pkg::EE_DOUT]);
    endproperty
    a_ee_data: assert property (p_ee_data) else $error("eeprom data not driven");

    property p_ee_idle;
        !ee_ctrl[mpg_pkg::EE_ACTIVE] |=> eeprom_serial_data_out && !eeprom_serial_data_oe_n;
    endproperty
    a_ee_idle: assert property (p_ee_idle) else $error("idle eeprom data not high");

    property p_scan_norm;
        !mfg_s |=> !scan_enable_out && !scan_enable_oe_n;
    endproperty
    a_scan_norm: assert property (p_scan_norm) else $error("scan pin not driving zero");

    property p_scan_test;
        mfg_s ##1 mfg_s |-> scan_enable_oe_n;
    endproperty
    a_scan_test: assert property (p_scan_test) else $error("scan pin not an input");

    property p_gpio_dir;
        ##1 gpio_oe_n == ~$past(gpio_oe);
    endproperty
    a_gpio_dir: assert property (p_gpio_dir) else $error("gpio direction mismatch");

    property p_gpio_reset;
        !strap_done |-> gpio_oe_n == 8'hff;
    endproperty
    a_gpio_reset: assert property (p_gpio_reset) else $error("gpio not input after reset");

    property p_strap_hold;
        strap_done ##1 1'b1 |-> $stable(smbus_address) && $stable(power_saving_enable)
                               && $stable(debug_mode);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap value changed");

    property p_strap_take;
        $rose(strap_done) |-> power_saving_enable == $past(pwr_s) &&
                              debug_mode == !$past(dbg_s) && smbus_address == $past(gpio_s[7:5]);
    endproperty
    a_strap_take: assert property (p_strap_take) else $error("strap captured wrongly");

    property p_status_en;
        ##1 port_status_oe_n == !$past(debug_mode && stoe_s);
    endproperty
    a_status_en: assert property (p_status_en) else $error("port status enable wrong");

    property p_status_val;
        !port_status_oe_n |-> port_status == $past(port_status_src);
    endproperty
    a_status_val: assert property (p_status_val) else $error("port status value wrong");

    property p_dbg_sel;
        debug_mode ##1 debug_mode |-> debug_select == $past(gpio_s[4:0]);
    endproperty
    a_dbg_sel: assert property (p_dbg_sel) else $error("debug select wrong");

    property p_apb_ready;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("apb ready timing wrong");

    c_ee_xfer:   cover property (ee_ctrl[mpg_pkg::EE_ACTIVE] ##1 eeprom_serial_clock);
    c_dbg_stat:  cover property (!port_status_oe_n && debug_mode);
    c_mfg_test:  cover property (scan_enable_oe_n);
    c_apb_err:   cover property (pready && pslverr);

endmodule

// ===== mpg_partner.sv
// Board-side model: GPIO pads with straps, EEPROM data line, SMBus master clock
module mpg_partner (
    input  wire logic       clock,
    input  wire logic [7:0] board_gpio,
    input  wire logic [7:0] gpio_out,
    input  wire logic [7:0] gpio_oe_n,
    output logic      [7:0] gpio_in,
    input  wire logic       ee_data_out,
    input  wire logic       ee_data_oe_n,
    input  wire logic       ee_answer,
    input  wire logic       ee_bit,
    output logic            ee_data_in,
    input  wire logic       smb_run,
    output logic            smb_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt = 0;
    logic tick = 1'b1;

    always_ff @(posedge clock) begin
        cnt <= (cnt == 3) ? 0 : cnt + 1;
        if (cnt == 3) begin
            tick <= ~tick;
        end
    end

    // Pads the device drives show its value, the rest the board level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            gpio_in[i] = !gpio_oe_n[i] ? gpio_out[i] : board_gpio[i];
        end
    end

    // Memory answers only when told to; otherwise the line floats to its pull-up
    assign ee_data_in = !ee_data_oe_n ? ee_data_out : (ee_answer ? ee_bit : 1'b1);
    // Master owns the bus clock; idle bus rests high on its pull-up
    assign smb_clock = smb_run ? tick : 1'b1;
endmodule

// ===== mpg_top_tb_top.sv
// Self-checking bench for the pin, strap and GPIO control block
module mpg_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, arst_n, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]  paddr, gpio_in, gpio_out, gpio_oe_n, board;
    logic [31:0] pwdata, prdata, rd;
    logic        ee_clk, ee_in, ee_out, ee_oe_n, ee_answer, ee_bit, smb_run, smb_clk;
    logic        scan_in, scan_out, scan_oe_n, mfg, pwr, dbg_n, stoe, ps_oe_n, pse, dbgm;
    logic [2:0]  ps_src, ps, smba;
    logic [4:0]  dsel;
    int          err_count, num_checks, m_oe, m_out;

    mpg_top mpg_top_inst (
        .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .eeprom_serial_clock(ee_clk), .eeprom_serial_data_in(ee_in),
        .eeprom_serial_data_out(ee_out), .eeprom_serial_data_oe_n(ee_oe_n),
        .smbus_clock_in(smb_clk), .scan_enable_in(scan_in), .scan_enable_out(scan_out),
        .scan_enable_oe_n(scan_oe_n), .manufacturing_test(mfg), .power_saving_strap(pwr),
        .debug_enable_strap(dbg_n), .status_output_enable_strap(stoe),
        .port_status_src(ps_src), .port_status(ps), .port_status_oe_n(ps_oe_n),
        .power_saving_enable(pse), .debug_mode(dbgm), .debug_select(dsel),
        .smbus_address(smba)
    );

    mpg_partner mpg_partner_inst (
        .clock(clock), .board_gpio(board), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .gpio_in(gpio_in), .ee_data_out(ee_out), .ee_data_oe_n(ee_oe_n),
        .ee_answer(ee_answer), .ee_bit(ee_bit), .ee_data_in(ee_in), .smb_run(smb_run),
        .smb_clock(smb_clk)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Caller enters just after a rising edge; one idle cycle follows each transfer
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wrap_up();
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Whole run is under two hundred cycles
    initial begin
        #100us;
        err_count++;
        wrap_up();
    end

    initial begin
        err_count = 0;
        num_checks = 0;
        void'($urandom(81));
        {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {mfg, scan_in, stoe, ee_answer, ee_bit, ps_src} = '0;
        {pwr, dbg_n, smb_run} = 3'b101;
        board = {3'h5, 5'($urandom)};
        wait_cyc(20);
        chk(gpio_oe_n, 8'hff);
        chk({scan_oe_n, scan_out}, 2'b00);
        chk({ee_clk, ee_out, ee_oe_n}, 3'b010);
        arst_n <= 1'b1;
        wait_cyc(6);
        smb_run <= 1'b0;
        chk({pse, dbgm, smba}, 5'b11101);
        pwr <= 1'b0;
        dbg_n <= 1'b1;
        board <= {3'h2, 5'($urandom)};
        wait_cyc(5);
        chk(dsel, board[4:0]);
        chk({pse, dbgm, smba}, 5'b11101);
        stoe <= 1'b1;
        ps_src <= 3'($urandom);
        wait_cyc(5);
        chk({ps_oe_n, ps}, {1'b0, ps_src});
        stoe <= 1'b0;
        wait_cyc(5);
        chk({ps_oe_n, ps}, 4'h8);
        apb(1'b0, mpg_pkg::ADDR_STRAP, '0);
        chk({rd[13], rd[6], rd[4]}, 3'b111);
        for (int i = 0; i < 4; i++) begin
            m_oe = $urandom & 255;
            m_out = $urandom & 255;
            board <= 8'($urandom);
            apb(1'b1, mpg_pkg::ADDR_GPIO_OE, m_oe);
            apb(1'b1, mpg_pkg::ADDR_GPIO_OUT, m_out);
            wait_cyc(4);
            chk({gpio_oe_n, gpio_out}, {~8'(m_oe), 8'(m_out)});
            apb(1'b0, mpg_pkg::ADDR_GPIO_IN, '0);
            chk(rd, ((m_oe & m_out) | (~m_oe & board)) & 255);
            apb(1'b0, mpg_pkg::ADDR_GPIO_OE, '0);
            chk(rd, m_oe);
        end
        apb(1'b0, 8'h40, '0);
        chk(rerr, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, mpg_pkg::ADDR_EE_CTRL, 32'h7);
        wait_cyc(3);
        chk({ee_clk, ee_out, ee_oe_n}, 3'b100);
        ee_answer <= 1'b1;
        apb(1'b1, mpg_pkg::ADDR_EE_CTRL, 32'h3);
        wait_cyc(4);
        chk(ee_oe_n, 1'b1);
        apb(1'b0, mpg_pkg::ADDR_EE_CTRL, '0);
        chk(rd[4], 1'b0);
        ee_answer <= 1'b0;
        apb(1'b1, mpg_pkg::ADDR_EE_CTRL, '0);
        wait_cyc(3);
        chk({ee_clk, ee_out, ee_oe_n}, 3'b010);
        mfg <= 1'b1;
        scan_in <= 1'b1;
        wait_cyc(4);
        chk({scan_oe_n, scan_out}, 2'b10);
        apb(1'b0, mpg_pkg::ADDR_STRAP, '0);
        chk({rd[14], rd[7]}, 2'b11);
        mfg <= 1'b0;
        wait_cyc(4);
        chk({scan_oe_n, scan_out}, 2'b00);
        // Mid-run reset with opposite power-saving and debug straps, random SMBus address pins
        arst_n <= 1'b0;
        stoe <= 1'b1;
        wait_cyc(3);
        arst_n <= 1'b1;
        wait_cyc(6);
        chk({pse, dbgm, smba}, {2'b00, board[7:5]});
        chk({dsel, ps_oe_n}, 6'h01);
        wrap_up();
    end
endmodule
